// ===== hw/wdt_core.sv
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "wdt_defs.svh"

// Summary of operation
// R01 - unactivated under software option, counter runs as free 7-bit timer
// R02 - software should clear soft reset bit when finding watchdog active
// R03 - software reads the timer twice and keeps matching values
// R04 - one decrement per 384 us step
// R05 - wait mode leaves counting and reset untouched
// R06 - stop with watchdog inactive enters stop mode
// R07 - active watchdog without external stop control turns stop into wait
// R08 - with external control, stop is wait if nmi low, else freeze and stop
// R09 - leaving stop on interrupt resumes counting from frozen value
// R10 - control register at D8h, read/write, resets to FEh
// R11 - bits 7:2 hold counter reversed, bit 7 is lsb
// R12 - soft reset bit zero with activation set gives mcu reset
// R13 - inactive, soft reset bit is timer msb; one means no reset
// R14 - hardware option forces activation bit high, writes cannot clear it
// R15 - software option: activation bit sticks until mcu reset
// R16 - counter decrements every 3072 oscillator cycles, 64 steps
// R17 - active with soft reset bit zero drives reset low about 500 ns
// R18 - software rewrites the register with 02h to FEh in time
// R19 - software option comes out of reset deactivated
// R20 - a write loads counter and soft reset bit at once
module wdt_core import wdt_pkg::*; #(
    parameter int STEP_CYCLES = `WDT_STEP_CYCLES,
    parameter int PULSE_CYCLES = `WDT_RST_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [`WDT_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic hw_activation_option_i,
    input wire logic external_stop_control_option_i,
    input wire logic nmi_i,
    input wire logic stop_instr_i,
    input wire logic wait_instr_i,
    input wire logic wake_i,
    output logic mcu_reset_n_o,
    output logic stop_mode_o,
    output logic wait_mode_o
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [5:0] wdt_rev6(input logic [5:0] v);
        logic [5:0] r;
        for (int i = 0; i < 6; i++)
            r[i] = v[5 - i];
        return r;
    endfunction

    function automatic logic [7:0] wdt_view(input logic [6:0] cnt, input logic act);
        return {wdt_rev6(cnt[5:0]), cnt[`WDT_CNT_MSB], act}; // R11
    endfunction

    // ----------------------------------------
    // state and sub-blocks
    // ----------------------------------------
    wdt_core_state_type st;
    wdt_core_state_type next_st;
    wdt_if link();
    logic active;
    logic req;
    logic hit;
    logic wr_hit;
    logic start;
    logic [7:0] ctrl_view;

    wdt_prescale #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_pre (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .link(link)
    );

    wdt_rst_pulse #(
        .PULSE_CYCLES(PULSE_CYCLES)
    ) u_pulse (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .link(link)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    assign active = st.c | hw_activation_option_i; // R14
    assign ctrl_view = wdt_view(st.cnt, active); // R10
    assign req = avs_read_i | avs_write_i;
    assign hit = avs_address_i == `WDT_ADDR_CTRL;
    assign wr_hit = avs_write_i && !st.waitreq && hit && avs_byteenable_i[0];
    // expiry is seen on the stored bit, so a write of SR=0 fires one edge later
    assign start = active && !st.cnt[`WDT_CNT_MSB] && !link.busy; // R12 R17
    // clocks stop in stop mode, timer use included
    assign link.tick_en = st.mode != WDT_STOP; // R08 R09
    assign link.start = start;

    always_comb
    begin
        next_st = st;
        next_st.rst_n = !(start || link.busy);

        // bus: one wait cycle, then the answer; write lands as the master is released
        if (req && st.waitreq)
        begin
            next_st.waitreq = 1'b0;
            next_st.rdata = (avs_read_i && hit) ? {24'h00_0000, ctrl_view} : 32'h0000_0000; // R10
        end
        else
        begin
            next_st.waitreq = 1'b1;
        end

        // counter: a write wins over the step decrement
        if (wr_hit)
        begin
            next_st.cnt = {avs_writedata_i[`WDT_BIT_SR], wdt_rev6(avs_writedata_i[7:2])}; // R20 R11 R13
            next_st.c = st.c | avs_writedata_i[`WDT_BIT_C]; // R15
        end
        // a step tick launched just before stop is dropped, so stop freezes at once
        else if (link.tick && st.mode != WDT_STOP)
        begin
            next_st.cnt = st.cnt - 7'h01; // R16 R01 R05
        end

        // power modes
        unique case (st.mode)
            WDT_RUN:
            begin
                if (stop_instr_i)
                begin
                    if (!active)
                        next_st.mode = WDT_STOP; // R06
                    else if (!external_stop_control_option_i || !nmi_i)
                        next_st.mode = WDT_WAIT; // R07 R08
                    else
                        next_st.mode = WDT_STOP; // R08
                end
                else if (wait_instr_i)
                begin
                    next_st.mode = WDT_WAIT; // R05
                end
            end
            WDT_WAIT, WDT_STOP:
            begin
                if (wake_i)
                    next_st.mode = WDT_RUN; // R09
            end
        endcase

        // the watchdog's own reset reloads counter, activation bit and mode as an mcu reset does; prescaler phase is kept
        if (link.busy)
        begin
            next_st.cnt = `WDT_CNT_RESET;
            next_st.c = 1'b0; // R15 R19
            next_st.mode = WDT_RUN;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st.cnt <= `WDT_CNT_RESET; // R10 R19
            st.c <= 1'b0;
            st.mode <= WDT_RUN;
            st.waitreq <= 1'b1;
            st.rdata <= 32'h0000_0000;
            st.rst_n <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign avs_readdata_o = st.rdata;
    assign avs_waitrequest_o = st.waitreq;
    assign mcu_reset_n_o = st.rst_n;
    assign stop_mode_o = st.mode == WDT_STOP;
    assign wait_mode_o = st.mode == WDT_WAIT;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_reset_view: assert property ($rose(nrst_i) |-> ctrl_view[7:1] == `WDT_CTRL_RESET >> 1) // R10
        else $error("control register reset value wrong");

    a_read_map: assert property (avs_read_i && hit && st.waitreq
        |=> avs_readdata_o[7:0] == $past(ctrl_view) && !avs_waitrequest_o) // R11
        else $error("read data does not show counter view");

    a_write_load: assert property (wr_hit && !link.busy
        |=> st.cnt == {$past(avs_writedata_i[1]), wdt_rev6($past(avs_writedata_i[7:2]))}) // R20
        else $error("write did not load counter");

    a_step_decr: assert property (link.tick && !wr_hit && !link.busy && st.mode != WDT_STOP
        |=> st.cnt == $past(st.cnt) - 7'h01) // R16
        else $error("counter did not step");

    a_stop_freeze: assert property (st.mode == WDT_STOP && !wr_hit && !link.busy
        |=> st.cnt == $past(st.cnt)) // R08
        else $error("counter moved in stop mode");

    a_stop_as_wait: assert property (st.mode == WDT_RUN && stop_instr_i && active
        && (!external_stop_control_option_i || !nmi_i) && !link.busy |=> wait_mode_o) // R07
        else $error("stop not taken as wait");

    a_stop_enter: assert property (st.mode == WDT_RUN && stop_instr_i && !link.busy
        && (!active || (external_stop_control_option_i && nmi_i)) |=> stop_mode_o) // R06
        else $error("stop mode not entered");

    a_wake_resume: assert property (st.mode != WDT_RUN && wake_i && !link.busy
        |=> st.mode == WDT_RUN) // R09
        else $error("wake did not resume");

    a_soft_reset: assert property (wr_hit && !link.busy && avs_writedata_i[0]
        && !avs_writedata_i[1] |=> ##1 !mcu_reset_n_o) // R12
        else $error("soft reset not raised");

    a_act_sticky: assert property (st.c && !link.busy |=> st.c) // R15
        else $error("activation bit cleared by software");

    a_hw_force: assert property (hw_activation_option_i |-> ctrl_view[0]) // R14
        else $error("activation bit not forced");

    a_idle_no_rst: assert property (!active && !link.busy |=> mcu_reset_n_o) // R13
        else $error("reset while watchdog inactive");

    c_timeout: cover property (active && link.tick && st.cnt == 7'h40);
    c_soft_reset: cover property (wr_hit && avs_writedata_i[0] && !avs_writedata_i[1]);
    c_stop_wake: cover property (st.mode == WDT_STOP ##[1:20] st.mode == WDT_RUN);
    c_read: cover property (avs_read_i && hit && !st.waitreq);
endmodule

// ===== hw/wdt_prescale.sv
`timescale 1ns/1ps
`include "wdt_defs.svh"

module wdt_prescale import wdt_pkg::*; #(
    parameter int STEP_CYCLES = `WDT_STEP_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    wdt_if.pre link
);
    localparam int CW = $clog2(STEP_CYCLES);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } wdt_pre_state_type;

    wdt_pre_state_type st;
    wdt_pre_state_type next_st;

    // phase is held, not cleared, while frozen so a stop resumes mid-step
    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (link.tick_en)
        begin
            if (st.cnt == CW'(STEP_CYCLES - 1))
            begin
                next_st.cnt = '0;
                next_st.tick = 1'b1; // R16
            end
            else
            begin
                next_st.cnt = st.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign link.tick = st.tick;

    a_tick_phase: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        st.tick |-> st.cnt == '0 && $past(st.cnt) == CW'(STEP_CYCLES - 1)) // R04
        else $error("step tick out of phase");
endmodule

// ===== hw/wdt_rst_pulse.sv
`timescale 1ns/1ps
`include "wdt_defs.svh"

module wdt_rst_pulse import wdt_pkg::*; #(
    parameter int PULSE_CYCLES = `WDT_RST_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    wdt_if.pulse link
);
    localparam int PW = $clog2(PULSE_CYCLES + 1);

    typedef struct packed {
        logic [PW-1:0] left;
    } wdt_pulse_state_type;

    wdt_pulse_state_type st;
    wdt_pulse_state_type next_st;

    always_comb
    begin
        next_st = st;
        if (st.left != '0)
            next_st.left = st.left - PW'(1);
        else if (link.start)
            next_st.left = PW'(PULSE_CYCLES); // R17
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign link.busy = st.left != '0;

    a_pulse_load: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        link.start && !link.busy |=> st.left == PW'(PULSE_CYCLES) ##1 st.left == PW'(PULSE_CYCLES - 1)) // R17
        else $error("reset pulse length wrong");
endmodule

// ===== include/wdt_defs.svh
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define WDT_ADDR_W 8
`define WDT_ADDR_CTRL 8'hD8
`define WDT_CTRL_RESET 8'hFE
`define WDT_CNT_RESET 7'h7F
`define WDT_BIT_SR 1
`define WDT_BIT_C 0
`define WDT_CNT_MSB 6

// ----------------------------------------
// timing
// ----------------------------------------
`define WDT_CLK_MHZ 250
`define WDT_STEP_NS 384000
`define WDT_STEP_CYCLES (`WDT_STEP_NS * `WDT_CLK_MHZ / 1000)
`define WDT_RST_NS 500
`define WDT_RST_CYCLES (`WDT_RST_NS * `WDT_CLK_MHZ / 1000)

`endif

// ===== include/wdt_if.sv
`timescale 1ns/1ps

interface wdt_if;
    logic tick_en;
    logic tick;
    logic start;
    logic busy;

    modport core (output tick_en, output start, input tick, input busy);
    modport pre (input tick_en, output tick);
    modport pulse (input start, output busy);
endinterface

// ===== include/wdt_pkg.sv
package wdt_pkg;

    typedef enum logic [1:0] {
        WDT_RUN,
        WDT_WAIT,
        WDT_STOP
    } wdt_mode_type;

    typedef struct packed {
        logic [6:0] cnt;
        logic c;
        wdt_mode_type mode;
        logic waitreq;
        logic [31:0] rdata;
        logic rst_n;
    } wdt_core_state_type;

endpackage

// ===== verification/wdt_core_test.sv
`timescale 1ns/1ps
`include "wdt_defs.svh"

module wdt_core_test import wdt_pkg::*;;
    // short counts keep the run brief
    localparam int STEP = 20;
    localparam int PULSE = 5;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic hw = 1'h0;
    logic ext = 1'h0;
    logic nmi = 1'h0;
    logic [2:0] ins = 3'h0;
    logic [7:0] addr = 8'hD8;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hF;
    logic [7:0] q;
    wire [31:0] rdata;
    wire waitreq, rst_n, stop_m, wait_m;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic ws_s = 1'h1;
    logic rs_s = 1'h1;
    logic [31:0] rd_s = 32'h0;

    always #2 clk = ~clk;

    // outputs taken at the falling edge hold what the next rising edge sees
    always @(negedge clk)
    begin
        ws_s <= waitreq;
        rd_s <= rdata;
        rs_s <= rst_n;
    end

    wdt_core #(.STEP_CYCLES(STEP), .PULSE_CYCLES(PULSE)) u_dut (
        .core_clk_i(clk), .nrst_i(nrst), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .hw_activation_option_i(hw), .external_stop_control_option_i(ext), .nmi_i(nmi),
        .stop_instr_i(ins[2]), .wait_instr_i(ins[1]), .wake_i(ins[0]), .mcu_reset_n_o(rst_n),
        .stop_mode_o(stop_m), .wait_mode_o(wait_m));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task give_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    task check(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // held until waitrequest is sampled low
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {24'h0, d};
        do
            @(posedge clk);
        while (ws_s !== 1'h0);
        q = rd_s[7:0];
        rd <= 1'h0;
        wr <= 1'h0;
    endtask

    function logic [7:0] enc(input logic [6:0] c, input logic a);
        return {c[0], c[1], c[2], c[3], c[4], c[5], c[6], a};
    endfunction

    function logic [6:0] dec(input logic [7:0] r);
        return {r[1], r[2], r[3], r[4], r[5], r[6], r[7]};
    endfunction

    task do_reset();
        @(posedge clk);
        nrst <= 1'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
    endtask

    task fire(input logic [2:0] m);
        @(posedge clk);
        ins <= m;
        @(posedge clk);
        ins <= 3'h0;
        repeat (2) @(posedge clk);
    endtask

    // two reads whose sampling edges lie exactly 4 steps apart
    task gap(input logic [6:0] drop, input string name);
        logic [6:0] v0;
        bus(1'h0, 8'hD8, 8'h00);
        v0 = dec(q);
        repeat (4 * STEP - 3) @(posedge clk);
        bus(1'h0, 8'hD8, 8'h00);
        check(name, dec(q), 7'(v0 - drop));
    endtask

    task wait_rst(input int lo, input int hi);
        int lat;
        int len;
        lat = 0;
        len = 0;
        do
        begin
            @(posedge clk);
            lat++;
        end
        while (rs_s !== 1'h0 && lat < 200);
        do
        begin
            @(posedge clk);
            len++;
        end
        while (rs_s === 1'h0);
        check("reset delay", lat >= lo && lat <= hi, 1'h1);
        check("reset length", len, PULSE + 1);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_refuse();
        bus(1'h0, 8'hD8, 8'h00);
        check("reset value", q, 8'hFE);
        bus(1'h0, 8'hD9, 8'h00);
        check("unmapped read", q, 8'h00);
        bus(1'h1, 8'hD9, 8'hFD);
        be <= 4'hE;
        bus(1'h1, 8'hD8, 8'hFD);
        be <= 4'hF;
        bus(1'h0, 8'hD8, 8'h00);
        check("ignored writes", {rst_n, q[1:0]}, 3'h6);
    endtask

    task t_timer(input logic [6:0] v);
        logic [7:0] q0;
        bus(1'h1, 8'hD8, enc(v, 1'h0));
        bus(1'h0, 8'hD8, 8'h00);
        check("load", 7'(v - dec(q)) <= 7'h01, 1'h1);
        q0 = q;
        bus(1'h0, 8'hD8, 8'h00);
        check("double read", 7'(dec(q0) - dec(q)) <= 7'h01, 1'h1);
        gap(7'h04, "timer step");
        check("no reset inactive", rst_n, 1'h1);
    endtask

    task t_mode(input logic a, input logic e, input logic n, input logic [2:0] m, input logic s);
        @(posedge clk);
        ext <= e;
        nmi <= n;
        if (a)
        begin
            bus(1'h1, 8'hD8, 8'hFF);
            bus(1'h1, 8'hD8, 8'hFE);
        end
        bus(1'h0, 8'hD8, 8'h00);
        check("activation sticks", q[0], a);
        fire(m);
        check("stop mode", stop_m, s);
        check("wait mode", wait_m, !s);
        gap(s ? 7'h00 : 7'h04, "count in mode");
        fire(3'h1);
        check("woken", {stop_m, wait_m}, 2'h0);
        if (s)
            gap(7'h04, "resume count");
        if (a)
        begin
            // the usual deactivation idiom: SR cleared with C set
            bus(1'h1, 8'hD8, 8'hFD);
            wait_rst(2, 2);
            bus(1'h0, 8'hD8, 8'h00);
            check("deactivated", q[0], 1'h0);
        end
    endtask

    task t_timeout();
        bus(1'h1, 8'hD8, enc(7'h40, 1'h1));
        wait_rst(3, STEP + 2);
    endtask

    task t_hw();
        hw <= 1'h1;
        do_reset();
        bus(1'h0, 8'hD8, 8'h00);
        check("hw reset value", q, 8'hFF);
        bus(1'h1, 8'hD8, 8'hFE);
        bus(1'h0, 8'hD8, 8'h00);
        check("hw forced", q[0], 1'h1);
        bus(1'h1, 8'hD8, 8'hFD);
        wait_rst(2, 2);
        hw <= 1'h0;
        do_reset();
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        t_refuse();
        t_timer(7'h55);
        t_timer(7'h02);
        t_mode(1'h0, 1'h0, 1'h0, 3'h4, 1'h1);
        t_mode(1'h1, 1'h0, 1'h1, 3'h4, 1'h0);
        t_mode(1'h1, 1'h1, 1'h0, 3'h4, 1'h0);
        t_mode(1'h1, 1'h1, 1'h1, 3'h4, 1'h1);
        t_mode(1'h1, 1'h0, 1'h0, 3'h2, 1'h0);
        t_timeout();
        t_hw();
        give_verdict();
    end
endmodule
